// ---- hw/sar_records.sv ----
`timescale 1ns/1ps
// How it works
// - erase record: id e5, flags 0003
// - byte 3 gives remaining life percent
// - bytes 5-10 hold total block erases
// - life below threshold flags threshold exceeded
// - total ecc record uses id cb
// - bytes 5-8 count all ecc errors
// - correctable ecc record cc, count bytes 5-8
// - crc record c7, crc errors bytes 5-8
// - read record e8, reads in bytes 5-10
// - power-on record 0c, cycles bytes 5-8
// - written record f1, blocks over 65536
// - read-volume record f2, blocks over 65536
// - advisory current and worst fixed 64h
// - advisory records carry flags 0002
// - only erase record feeds threshold check
// - byte 4 holds the worst value
// - multi-byte fields least significant byte first
// - twelve-byte entries from sector byte 2
// - erase threshold defaults to 01h
module sar_records
  import sar_pkg::*;
#(
  parameter logic [7:0] ERASE_THRESH = ERASE_THRESH_DEF,
  parameter logic [31:0] ERASE_PER_PCT = ERASE_PER_PCT_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire sar_evt_s evt_i,
  input wire logic rd_en_i,
  input wire logic [8:0] sec_addr_i,
  output logic [7:0] rec_byte_o,
  output logic rd_valid_o,
  output logic thr_exceeded_o
);

  logic [RAW_W-1:0] cnt_q [NUM_REC];
  logic [NUM_REC-1:0] inc;
  logic [NUM_REC-1:0] sat;
  logic [1:0] lba_evt;
  logic [1:0] lba_carry;
  logic [LBA_DIV_W-1:0] pre_q [2];
  logic [31:0] step_q;
  logic [31:0] step_d;
  logic [7:0] life_q;
  logic [7:0] life_d;
  logic [7:0] worst_q;
  logic thr_q;
  logic [7:0] rec_byte_q;
  logic rd_valid_q;
  sar_rec_s rec [NUM_REC];
  logic [8:0] off;
  logic [8:0] ent;
  logic [8:0] byt;
  logic [7:0] byte_d;

  // block volume events pass a 65536 prescaler before counting
  assign lba_evt = {evt_i.lba_rd, evt_i.lba_wr};

  // per-volume prescaler; wraps freely, the main counter saturates
  for (genvar j = 0; j < 2; j++) begin : g_pre
    assign lba_carry[j] = lba_evt[j] && (pre_q[j] == '1);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pre_q[j] <= '0;
      end else if (lba_evt[j]) begin
        pre_q[j] <= pre_q[j] + 1'b1;
      end
    end
  end

  // increment sources, slot order matches the record table
  assign inc[R_ERASE] = evt_i.erase;
  assign inc[R_ECC_TOT] = evt_i.ecc_corr || evt_i.ecc_uncorr;
  assign inc[R_ECC_COR] = evt_i.ecc_corr;
  assign inc[R_CRC] = evt_i.crc_err;
  assign inc[R_READS] = evt_i.flash_rd;
  assign inc[R_PWR_ON] = evt_i.power_on;
  assign inc[R_LBA_WR] = lba_carry[0];
  assign inc[R_LBA_RD] = lba_carry[1];

  // saturating counters and record assembly, one per slot
  for (genvar i = 0; i < NUM_REC; i++) begin : g_rec
    localparam logic [RAW_W-1:0] MAXV = {RAW_W{1'b1}} >> (RAW_W - CNT_W[i]);
    assign sat[i] = (cnt_q[i] == MAXV);

    // stop at the field maximum so a full field never reads small
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_q[i] <= '0;
      end else if (inc[i] && !sat[i]) begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end

    // four-byte counters zero-extend, so bytes 9-10 read zero
    if (i == R_ERASE) begin : g_pf
      assign rec[i] = '{rsvd: RSVD_VAL,
                        raw: cnt_q[i],
                        worst: worst_q,
                        cur: life_q,
                        flags: FLAGS_PREFAIL,
                        id: REC_ID[i]};
    end else begin : g_adv
      assign rec[i] = '{rsvd: RSVD_VAL,
                        raw: cnt_q[i],
                        worst: FIXED_VAL,
                        cur: FIXED_VAL,
                        flags: FLAGS_ADVISORY,
                        id: REC_ID[i]};
    end
  end

  // next life value; worst value reads it so it never lags
  always_comb begin
    step_d = step_q;
    life_d = life_q;
    if (evt_i.erase) begin
      if (step_q >= ERASE_PER_PCT - 32'h1) begin
        step_d = '0;
        if (life_q != 8'h00) begin
          life_d = life_q - 8'h01;
        end
      end else begin
        step_d = step_q + 32'h1;
      end
    end
  end

  // life estimate: one percent lost per ERASE_PER_PCT erases;
  // avoids a divider at the cost of a fixed step size
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_q <= '0;
      life_q <= FULL_LIFE;
    end else begin
      step_q <= step_d;
      life_q <= life_d;
    end
  end

  // worst value is the lowest life seen since reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      worst_q <= FULL_LIFE;
    end else if (life_d < worst_q) begin
      worst_q <= life_d;
    end
  end

  // only the erase record takes part in the health check
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thr_q <= 1'b0;
    end else begin
      thr_q <= (life_q < ERASE_THRESH);
    end
  end

  // sector byte address to entry and byte within entry
  assign off = sec_addr_i - SEC_START;
  assign ent = off / 9'(REC_BYTES);
  assign byt = off % 9'(REC_BYTES);

  // entries past the covered records, and framing bytes, read zero
  always_comb begin
    byte_d = 8'h00;
    if (sec_addr_i >= SEC_START && sec_addr_i < SEC_END &&
        ent < 9'(NUM_REC)) begin
      byte_d = rec[ent[2:0]][{byt[3:0], 3'b000} +: 8];
    end
  end

  // read port: one-cycle latency, byte held until the next read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rec_byte_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en_i;
      if (rd_en_i) begin
        rec_byte_q <= byte_d;
      end
    end
  end

  assign rec_byte_o = rec_byte_q;
  assign rd_valid_o = rd_valid_q;
  assign thr_exceeded_o = thr_q;

  // checking helpers: address of the byte on the output
  logic [8:0] a_addr_q;
  logic [8:0] a_ent_q;
  logic [8:0] a_byt_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_addr_q <= '0;
      a_ent_q <= '0;
      a_byt_q <= '0;
    end else if (rd_en_i) begin
      a_addr_q <= sec_addr_i;
      a_ent_q <= ent;
      a_byt_q <= byt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // a read of byte b of entry e that lands inside the record area
  sequence s_rd_at(int e, int b);
    rd_en_i && sec_addr_i >= SEC_START && sec_addr_i < SEC_END &&
    ent == 9'(e) && byt == 9'(b);
  endsequence

  property p_byte_is(int e, int b, logic [7:0] v);
    s_rd_at(e, b) |=> rd_valid_o && rec_byte_o == v;
  endproperty

  a_erase_id: assert property (p_byte_is(0, 0, 8'he5))
    else $error("erase record id wrong");
  a_erase_flags: assert property (p_byte_is(0, 1, 8'h03))
    else $error("erase record flag word wrong");
  a_life_byte: assert property (
    s_rd_at(0, 3) |=> rec_byte_o == $past(life_q))
    else $error("life percent byte does not follow estimate");
  a_erase_raw: assert property (
    s_rd_at(0, 6) |=> rec_byte_o == $past(cnt_q[0][15:8]))
    else $error("erase count byte 6 wrong or wrong order");
  a_thr_flag: assert property (
    $rose(life_q < ERASE_THRESH) |=> thr_exceeded_o [*2])
    else $error("threshold exceeded not raised");
  a_ecc_id: assert property (p_byte_is(1, 0, 8'hcb))
    else $error("total ecc id wrong");
  a_ecc_total: assert property (
    evt_i.ecc_uncorr && !sat[1] |=> cnt_q[1] == $past(cnt_q[1]) + 48'h1)
    else $error("uncorrectable error not counted in total");
  a_corr_id: assert property (p_byte_is(2, 0, 8'hcc))
    else $error("correctable ecc id wrong");
  a_crc_id: assert property (p_byte_is(3, 0, 8'hc7))
    else $error("crc record id wrong");
  a_reads_cnt: assert property (
    evt_i.flash_rd && !sat[4] |=> cnt_q[4] == $past(cnt_q[4]) + 48'h1)
    else $error("flash read not counted");
  a_pwr_id: assert property (p_byte_is(5, 0, 8'h0c))
    else $error("power-on record id wrong");
  a_lba_scale: assert property (
    cnt_q[6] != $past(cnt_q[6]) |-> $past(lba_evt[0] && pre_q[0] == '1))
    else $error("written volume stepped without 65536 blocks");
  a_rdvol_id: assert property (p_byte_is(7, 0, 8'hf2))
    else $error("read volume id wrong");
  a_adv_values: assert property (
    rd_valid_o && a_ent_q != 9'h0 && a_ent_q < 9'(NUM_REC) &&
    (a_byt_q == 9'h3 || a_byt_q == 9'h4) |-> rec_byte_o == 8'h64)
    else $error("advisory value not 100");
  a_adv_flags: assert property (p_byte_is(4, 1, 8'h02))
    else $error("advisory flag word wrong");
  a_thr_only: assert property (
    (life_q >= ERASE_THRESH) [*2] |-> !thr_exceeded_o)
    else $error("threshold flag without erase cause");
  a_worst_min: assert property (worst_q <= life_q)
    else $error("worst value above current value");
  a_outside: assert property (
    rd_en_i && (sec_addr_i < SEC_START || ent >= 9'(NUM_REC))
    |=> rec_byte_o == 8'h00)
    else $error("byte outside records not zero");
  a_zero_bytes: assert property (
    rd_valid_o && a_ent_q < 9'(NUM_REC) && a_addr_q >= SEC_START &&
    (a_byt_q == 9'h00b ||
     (CNT_W[a_ent_q[2:0]] == 32 && a_byt_q >= 9'h009)) |-> rec_byte_o == 8'h00)
    else $error("reserved byte not zero");
  a_sat_hold: assert property (
    inc[3] |=> cnt_q[3] != 48'h0 && cnt_q[3] >= $past(cnt_q[3]))
    else $error("counter wrapped after saturation");

  // read port: one answer per taken request, byte held between reads
  sequence s_taken;
    rd_en_i;
  endsequence

  sequence s_idle;
    !rd_en_i;
  endsequence

  a_valid_pulse: assert property (s_taken |=> rd_valid_o)
    else $error("read answer missing");
  a_valid_quiet: assert property (s_idle |=> !rd_valid_o)
    else $error("read answer without request");
  a_byte_hold: assert property (s_idle |=> $stable(rec_byte_o))
    else $error("output byte changed without request");

  // remaining identifiers and flag bytes
  a_reads_id: assert property (p_byte_is(4, 0, 8'he8))
    else $error("read count id wrong");
  a_wrvol_id: assert property (p_byte_is(6, 0, 8'hf1))
    else $error("written volume id wrong");
  a_flag_high: assert property (p_byte_is(0, 2, 8'h00))
    else $error("erase flag word high byte not zero");
  a_adv_flag_hi: assert property (p_byte_is(3, 2, 8'h00))
    else $error("advisory flag word high byte not zero");
  a_crc_flags: assert property (p_byte_is(3, 1, 8'h02))
    else $error("crc flag word wrong");
  a_corr_flags: assert property (p_byte_is(2, 1, 8'h02))
    else $error("correctable ecc flag word wrong");

  // life: one percent per step, never rises, threshold from life only; double ecc count once, read volume scale
  sequence s_life_step;
    evt_i.erase && step_q == ERASE_PER_PCT - 32'h1 && life_q != 8'h00;
  endsequence

  a_life_step: assert property (
    s_life_step |=> life_q == $past(life_q) - 8'h01)
    else $error("life did not drop one percent");
  a_life_mono: assert property (life_q <= $past(life_q))
    else $error("life estimate rose");
  a_worst_same: assert property (worst_q == life_q)
    else $error("worst value lags the current value");
  a_thr_cause: assert property (
    thr_exceeded_o |-> $past(life_q) < ERASE_THRESH)
    else $error("threshold flag without low life");
  a_ecc_once: assert property (
    evt_i.ecc_corr && evt_i.ecc_uncorr && !sat[1]
    |=> cnt_q[1] == $past(cnt_q[1]) + 48'h1)
    else $error("double ecc event not counted once");
  a_rdvol_scale: assert property (
    cnt_q[7] != $past(cnt_q[7]) |-> $past(lba_evt[1] && pre_q[1] == '1))
    else $error("read volume stepped without 65536 blocks");

  // per slot: one step per event and never beyond its field
  for (genvar k = 0; k < NUM_REC; k++) begin : g_chk
    a_cnt_step: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      inc[k] && !sat[k] |=> cnt_q[k] == $past(cnt_q[k]) + 48'h1)
      else $error("counter did not step by one");
    a_cnt_field: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cnt_q[k] >> CNT_W[k]) == 48'h0)
      else $error("counter beyond its field width");
  end

endmodule

// ---- hw/sar_pkg.sv ----
package sar_pkg;

  // record geometry inside the returned health data sector
  localparam int unsigned NUM_REC = 8;
  localparam int unsigned MAX_ENT = 30;
  localparam int unsigned REC_BYTES = 12;
  localparam logic [8:0] SEC_START = 9'h002;
  localparam logic [8:0] SEC_END = 9'h16a; // start + 30 * 12

  // record slots in sector order
  localparam int unsigned R_ERASE = 0;
  localparam int unsigned R_ECC_TOT = 1;
  localparam int unsigned R_ECC_COR = 2;
  localparam int unsigned R_CRC = 3;
  localparam int unsigned R_READS = 4;
  localparam int unsigned R_PWR_ON = 5;
  localparam int unsigned R_LBA_WR = 6;
  localparam int unsigned R_LBA_RD = 7;

  // attribute identifiers per slot
  localparam logic [7:0] REC_ID [NUM_REC] = '{
    8'he5, 8'hcb, 8'hcc, 8'hc7, 8'he8, 8'h0c, 8'hf1, 8'hf2
  };

  // raw counter field width per slot, bytes 5..10 or 5..8
  localparam int unsigned CNT_W [NUM_REC] = '{
    48, 32, 32, 32, 48, 32, 48, 48
  };
  localparam int unsigned RAW_W = 48;

  // flag words and fixed values
  localparam logic [15:0] FLAGS_PREFAIL = 16'h0003;
  localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;
  localparam logic [7:0] FIXED_VAL = 8'h64;
  localparam logic [7:0] FULL_LIFE = 8'h64;
  localparam logic [7:0] RSVD_VAL = 8'h00;

  // defaults for module parameters
  localparam logic [7:0] ERASE_THRESH_DEF = 8'h01;
  localparam logic [31:0] ERASE_PER_PCT_DEF = 32'h0000_03e8;
  localparam int unsigned LBA_DIV_W = 16; // divide by 65536

  // one record, byte 0 in the low bits so bytes leave lsb first
  typedef struct packed {
    logic [7:0] rsvd;
    logic [47:0] raw;
    logic [7:0] worst;
    logic [7:0] cur;
    logic [15:0] flags;
    logic [7:0] id;
  } sar_rec_s;

  // one-cycle event pulses from the flash back end and interface
  typedef struct packed {
    logic lba_rd;
    logic lba_wr;
    logic power_on;
    logic flash_rd;
    logic crc_err;
    logic ecc_uncorr;
    logic ecc_corr;
    logic erase;
  } sar_evt_s;

endpackage

// ---- dv/sar_host_model.sv ----
`timescale 1ns/1ps
// host side reader of the health data sector, one byte per request
module sar_host_model (
  input wire logic ref_clk_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rec_byte_i,
  output logic rd_en_o,
  output logic [8:0] sec_addr_o
);
  // idle at time zero so no stray request is taken
  initial begin
    rd_en_o = 1'b0;
    sec_addr_o = 9'h000;
  end

  // request held for exactly the taking edge, answer caught one cycle on
  task automatic read_byte(input logic [8:0] a, output logic [7:0] d,
                           output logic ok);
    @(posedge ref_clk_i);
    rd_en_o <= 1'b1;
    sec_addr_o <= a;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    sec_addr_o <= ~a; // stale address scrambled, not left looking valid
    #1;
    ok = rd_valid_i;
    d = rec_byte_i;
  endtask
endmodule

// ---- dv/sar_records_tb_top.sv ----
`timescale 1ns/1ps
module sar_records_tb_top;
  import sar_pkg::*;
  localparam logic [7:0] EXP_ID [8] = '{
    8'he5, 8'hcb, 8'hcc, 8'hc7, 8'he8, 8'h0c, 8'hf1, 8'hf2
  };
  logic ref_clk_i;
  logic rst_n_i;
  logic rd_en;
  logic rd_valid;
  logic thr;
  logic [8:0] addr;
  logic [7:0] rbyte;
  sar_evt_s evt;
  int failures;
  int n_compared;

  // tiny erase step keeps the life countdown to a few hundred cycles
  sar_records #(.ERASE_PER_PCT(32'h0000_0002)) dut_u (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .evt_i(evt),
    .rd_en_i(rd_en),
    .sec_addr_i(addr),
    .rec_byte_o(rbyte),
    .rd_valid_o(rd_valid),
    .thr_exceeded_o(thr)
  );

  sar_host_model host_u (
    .ref_clk_i(ref_clk_i),
    .rd_valid_i(rd_valid),
    .rec_byte_i(rbyte),
    .rd_en_o(rd_en),
    .sec_addr_o(addr)
  );

  // 50 mhz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entry e, byte b of the sector; also demands the valid pulse
  task automatic rd_chk(input int e, input int b, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.read_byte(9'(2 + 12 * e + b), d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask

  // n back-to-back event cycles, then quiet
  task automatic pulse(input sar_evt_s e, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      evt <= e;
    end
    @(posedge ref_clk_i);
    evt <= '0;
  endtask

  task automatic t_headers();
    for (int e = 0; e < 8; e++) begin
      rd_chk(e, 0, EXP_ID[e]);
      rd_chk(e, 1, (e == 0) ? 8'h03 : 8'h02);
      rd_chk(e, 2, 8'h00);
      rd_chk(e, 3, 8'h64);
      rd_chk(e, 4, 8'h64);
      rd_chk(e, 11, 8'h00);
    end
    rd_chk(0, -2, 8'h00);
    rd_chk(8, 0, 8'h00);
    rd_chk(30, 0, 8'h00);
  endtask

  // both ecc flags in one cycle still count once in the total
  task automatic t_counters();
    sar_evt_s e;
    e = '0;
    e.ecc_corr = 1'b1;
    e.ecc_uncorr = 1'b1;
    pulse(e, 2);
    e.ecc_uncorr = 1'b0;
    pulse(e, 1);
    e = '0;
    e.ecc_uncorr = 1'b1;
    pulse(e, 1);
    e = '0;
    e.crc_err = 1'b1;
    pulse(e, 5);
    e = '0;
    e.flash_rd = 1'b1;
    pulse(e, 258);
    e = '0;
    e.power_on = 1'b1;
    pulse(e, 2);
    #1;
    check({7'h00, thr}, 8'h00);
    rd_chk(1, 5, 8'h04);
    rd_chk(1, 9, 8'h00);
    rd_chk(2, 5, 8'h03);
    rd_chk(3, 5, 8'h05);
    rd_chk(4, 5, 8'h02);
    rd_chk(4, 6, 8'h01);
    rd_chk(5, 5, 8'h02);
    rd_chk(5, 10, 8'h00);
  endtask

  // two erases per percent: 198 leaves 1 percent, 200 leaves none
  task automatic t_erase();
    sar_evt_s e;
    e = '0;
    e.erase = 1'b1;
    pulse(e, 3);
    rd_chk(0, 3, 8'h63);
    rd_chk(0, 4, 8'h63);
    rd_chk(0, 5, 8'h03);
    pulse(e, 195);
    repeat (3) @(posedge ref_clk_i);
    #1;
    check({7'h00, thr}, 8'h00);
    pulse(e, 2);
    repeat (3) @(posedge ref_clk_i);
    #1;
    check({7'h00, thr}, 8'h01);
    rd_chk(0, 3, 8'h00);
    rd_chk(0, 4, 8'h00);
    rd_chk(0, 5, 8'hc8);
  endtask

  // counters are volatile: a reset in mid-run restores a fresh card
  task automatic t_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check({7'h00, thr}, 8'h00);
    rd_chk(0, 3, 8'h64);
    rd_chk(0, 4, 8'h64);
    rd_chk(0, 5, 8'h00);
    rd_chk(1, 5, 8'h00);
    rd_chk(4, 6, 8'h00);
  endtask

  // volume counters carry only on the 65536th block
  task automatic t_volume();
    sar_evt_s e;
    e = '0;
    e.lba_wr = 1'b1;
    e.lba_rd = 1'b1;
    pulse(e, 65535);
    rd_chk(6, 5, 8'h00);
    pulse(e, 1);
    rd_chk(6, 5, 8'h01);
    rd_chk(7, 5, 8'h01);
  endtask

  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    evt = '0;
    rst_n_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_headers();
    t_counters();
    t_erase();
    t_reset();
    t_volume();
    close_out();
  end

  // watchdog, well beyond the ~67k cycles the tests need
  initial begin
    #1_800_000;
    failures++;
    close_out();
  end
endmodule
